// file: ebha_params.svh
// ebha_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the link and adapter modules by bare name
`ifndef EBHA_PARAMS_SVH
`define EBHA_PARAMS_SVH

// ---------------------------------------------
// controller register offsets (word index)
// ---------------------------------------------
`define EBHA_OFF_CTRL 4'h0
`define EBHA_OFF_ADDR 4'h1
`define EBHA_OFF_WDATA 4'h2
`define EBHA_OFF_RDATA 4'h3
`define EBHA_OFF_STATUS 4'h4
`define EBHA_OFF_STRAPS 4'h5
`define EBHA_OFF_BASE 4'h6

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define EBHA_CTRL_GO_WR 0
`define EBHA_CTRL_GO_RD 1
`define EBHA_STAT_BUSY 0
`define EBHA_STAT_DONE 1
`define EBHA_STAT_TMO 2
`define EBHA_STAT_IN_WIN 3

// ---------------------------------------------
// reset values and device map
// ---------------------------------------------
`define EBHA_BASE_RST 8'h01
`define EBHA_STRAP_RST 6'h2f
`define EBHA_REG_WIN_START 16'hffe0
`define EBHA_DISP_BUF_BYTES 17'h0_a000
`define EBHA_BLOCK_BYTES 17'h1_0000

// ---------------------------------------------
// timing counts
// ---------------------------------------------
`define EBHA_SETUP_NS 24
`define EBHA_LINK_NS 12
`define EBHA_SETUP_CYC ((`EBHA_SETUP_NS + `EBHA_LINK_NS - 1) / `EBHA_LINK_NS)
`define EBHA_WAIT_TMO_CYC 1000

`endif

// file: ebha_pkg.sv
// ebha_pkg.sv: types shared by the adapter and its link-side engine
// assumes: ebha_params.svh holds the numbers
package ebha_pkg;

   // ---------------------------------------------
   // request passed to the link side
   // ---------------------------------------------
   typedef struct packed {
      logic write;
      logic [23:0] addr;
      logic [7:0] data;
   } ebha_req_t;

   // ---------------------------------------------
   // answer passed back from the link side
   // ---------------------------------------------
   typedef struct packed {
      logic timeout;
      logic [7:0] data;
   } ebha_rsp_t;

   // ---------------------------------------------
   // straps driven from the adapter's strap register, latched by the device at reset release
   // ---------------------------------------------
   typedef struct packed {
      logic bus_status;
      logic panel_power_polarity;
      logic byte_order;
      logic [2:0] bus_mode;
   } ebha_straps_t;

endpackage : ebha_pkg

// file: ebha_link.sv
// ebha_link.sv: link-side bus cycle engine on the host port clock
// assumes: req is held stable while go_tgl differs from done_tgl
`timescale 1ns/100ps
`include "ebha_params.svh"
`default_nettype none

module ebha_link #(
   parameter int TMO_CYC = `EBHA_WAIT_TMO_CYC
) (
   input wire logic host_port_clock,
   input wire logic link_rst_n,
   input wire logic go_tgl,
   input wire ebha_pkg::ebha_req_t req,
   output logic done_tgl,
   output ebha_pkg::ebha_rsp_t rsp,
   output logic [15:1] host_addr_upper,
   output logic host_addr_lsb,
   output logic chip_select_n,
   output logic upper_byte_enable_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [15:0] data_out,
   output logic data_oe,
   input wire logic [15:0] data_in,
   input wire logic wait_n
);

   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} ebha_lst_t;

   localparam logic [3:0] SETUP_C = 4'(`EBHA_SETUP_CYC);
   localparam logic [15:0] TMO_C = 16'(TMO_CYC);

   ebha_lst_t st_r, st_nxt;
   logic go_s1_r, go_s2_r, go_seen_r, go_seen_nxt;
   logic wait_s1_r, wait_s2_r;
   logic done_r, done_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   ebha_pkg::ebha_rsp_t rsp_r, rsp_nxt;
   logic cs_r, cs_nxt, we_r, we_nxt, rd_r, rd_nxt, oe_r, oe_nxt;

   // ---------------------------------------------
   // synchronisers for the go toggle and the wait pin
   // ---------------------------------------------
   always_ff @(posedge host_port_clock)
   begin
      if (!link_rst_n)
      begin
         go_s1_r <= 1'b0;
         go_s2_r <= 1'b0;
         wait_s1_r <= 1'b1;
         wait_s2_r <= 1'b1;
      end
      else
      begin
         go_s1_r <= go_tgl;
         go_s2_r <= go_s1_r;
         wait_s1_r <= wait_n;
         wait_s2_r <= wait_s1_r;
      end
   end

   // ---------------------------------------------
   // cycle sequencing: setup, strobe until wait released or timeout, hold
   // ---------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      go_seen_nxt = go_seen_r;
      done_nxt = done_r;
      cnt_nxt = cnt_r;
      rsp_nxt = rsp_r;
      cs_nxt = cs_r;
      we_nxt = we_r;
      rd_nxt = rd_r;
      oe_nxt = oe_r;
      unique case (st_r)
         ST_IDLE:
         begin
            if (go_s2_r != go_seen_r)
            begin
               go_seen_nxt = go_s2_r;
               cs_nxt = 1'b1;
               oe_nxt = req.write;
               cnt_nxt = 16'(SETUP_C);
               st_nxt = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            if (cnt_r > 16'h0001)
               cnt_nxt = cnt_r - 16'h0001;
            else
            begin
               we_nxt = req.write;
               rd_nxt = !req.write;
               cnt_nxt = TMO_C;
               st_nxt = ST_STROBE;
            end
         end
         ST_STROBE:
         begin
            // strobe held until the device lets go of wait or the timeout count reaches zero
            if (wait_s2_r || cnt_r == 16'h0000)
            begin
               rsp_nxt.timeout = !wait_s2_r;
               rsp_nxt.data = host_addr_lsb ? data_in[15:8] : data_in[7:0];
               we_nxt = 1'b0;
               rd_nxt = 1'b0;
               st_nxt = ST_HOLD;
            end
            else
               cnt_nxt = cnt_r - 16'h0001;
         end
         ST_HOLD:
         begin
            cs_nxt = 1'b0;
            oe_nxt = 1'b0;
            done_nxt = !done_r;
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge host_port_clock)
   begin
      if (!link_rst_n)
      begin
         st_r <= ST_IDLE;
         go_seen_r <= 1'b0;
         done_r <= 1'b0;
         cnt_r <= 16'h0000;
         rsp_r <= '0;
         cs_r <= 1'b0;
         we_r <= 1'b0;
         rd_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         go_seen_r <= go_seen_nxt;
         done_r <= done_nxt;
         cnt_r <= cnt_nxt;
         rsp_r <= rsp_nxt;
         cs_r <= cs_nxt;
         we_r <= we_nxt;
         rd_r <= rd_nxt;
         oe_r <= oe_nxt;
      end
   end

   // ---------------------------------------------
   // pin drive; address and data from the held request
   // ---------------------------------------------
   assign host_addr_upper = req.addr[15:1];
   assign host_addr_lsb = req.addr[0];
   assign chip_select_n = !cs_r;
   assign upper_byte_enable_n = !(cs_r && req.addr[0]);
   assign data_out = {req.data, req.data};
   assign data_oe = oe_r;
   assign write_strobe_n = !we_r;
   assign read_strobe_n = !rd_r;
   assign done_tgl = done_r;
   assign rsp = rsp_r;

endmodule : ebha_link

`default_nettype wire

// file: ebha_adapter.sv
// ebha_adapter.sv: 8-bit host controller driving a 16-bit display controller port
// assumes: system clock 125 MHz; host_port_clock is unrelated; straps wired on board
`timescale 1ns/100ps
`include "ebha_params.svh"
`default_nettype none

module ebha_adapter #(
   parameter int TMO_CYC = `EBHA_WAIT_TMO_CYC,
   parameter logic [5:0] STRAP_VAL = `EBHA_STRAP_RST
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_port_clock,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic [15:1] host_addr_upper,
   output logic host_addr_lsb,
   output logic chip_select_n,
   output logic upper_byte_enable_n,
   output logic write_strobe_n,
   output logic read_strobe_n,
   output logic [15:0] host_data_bus_out,
   output logic host_data_bus_oe,
   input wire logic [15:0] host_data_bus_in,
   input wire logic wait_n,
   output logic bus_status_strap,
   output logic direction_tie,
   output logic [2:0] bus_mode_straps,
   output logic byte_order_strap,
   output logic panel_power_polarity_strap,
   output logic device_reset_n
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic [7:0] base_r, base_nxt;
   logic [15:0] offs_r, offs_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic write_r, write_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic tmo_r, tmo_nxt;
   logic go_r, go_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic dn_s1_r, dn_s2_r, dn_seen_r, dn_seen_nxt;
   logic lrst_s1_r, lrst_s2_r;
   logic [5:0] strap_r, strap_nxt;
   logic dev_rst_r, dev_rst_nxt;
   logic link_done;
   logic dn_evt;
   logic in_win;
   logic [31:0] stat_w;
   logic [15:0] din_s1_r, din_s2_r;
   ebha_pkg::ebha_req_t req;
   ebha_pkg::ebha_rsp_t rsp;
   ebha_pkg::ebha_straps_t straps;

   // ---------------------------------------------
   // address map checks
   // ---------------------------------------------
   // display buffer or register set; gap between them is still in the block
   assign in_win = (17'(offs_r) < `EBHA_DISP_BUF_BYTES)
                   || (offs_r >= `EBHA_REG_WIN_START);
   assign dn_evt = dn_s2_r != dn_seen_r;

   // ---------------------------------------------
   // status word; unused bits read zero
   // ---------------------------------------------
   always_comb
   begin
      stat_w = 32'h0000_0000;
      stat_w[`EBHA_STAT_BUSY] = busy_r;
      stat_w[`EBHA_STAT_DONE] = done_r;
      stat_w[`EBHA_STAT_TMO] = tmo_r;
      stat_w[`EBHA_STAT_IN_WIN] = in_win;
   end

   // ---------------------------------------------
   // register writes, request launch and completion
   // ---------------------------------------------
   always_comb
   begin
      base_nxt = base_r;
      offs_nxt = offs_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      write_nxt = write_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      tmo_nxt = tmo_r;
      go_nxt = go_r;
      dn_seen_nxt = dn_seen_r;
      strap_nxt = strap_r;
      dev_rst_nxt = 1'b1; // device reset released one cycle after ours
      if (reg_write && !busy_r)
      begin
         unique case (reg_addr)
            `EBHA_OFF_ADDR: offs_nxt = reg_wdata[15:0];
            `EBHA_OFF_WDATA: wdata_nxt = reg_wdata[7:0];
            `EBHA_OFF_BASE: base_nxt = reg_wdata[7:0];
            `EBHA_OFF_STRAPS: strap_nxt = reg_wdata[5:0];
            `EBHA_OFF_CTRL:
            begin
               if (reg_wdata[`EBHA_CTRL_GO_WR] || reg_wdata[`EBHA_CTRL_GO_RD])
               begin
                  write_nxt = reg_wdata[`EBHA_CTRL_GO_WR];
                  busy_nxt = 1'b1;
                  done_nxt = 1'b0;
                  tmo_nxt = 1'b0;
                  go_nxt = !go_r;
               end
            end
            default: ;
         endcase
      end
      if (dn_evt)
      begin
         dn_seen_nxt = dn_s2_r;
         busy_nxt = 1'b0;
         done_nxt = 1'b1; // completion wins over any clear
         tmo_nxt = rsp.timeout;
         if (!write_r)
            rdata_nxt = rsp.data;
      end
   end

   // ---------------------------------------------
   // read data, one cycle after the read strobe
   // ---------------------------------------------
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      if (reg_read)
      begin
         unique case (reg_addr)
            `EBHA_OFF_ADDR: rd_nxt = {16'h0000, offs_r};
            `EBHA_OFF_WDATA: rd_nxt = {24'h00_0000, wdata_r};
            `EBHA_OFF_RDATA: rd_nxt = {24'h00_0000, rdata_r};
            `EBHA_OFF_BASE: rd_nxt = {24'h00_0000, base_r};
            `EBHA_OFF_STRAPS: rd_nxt = {26'h000_0000, strap_r};
            `EBHA_OFF_STATUS: rd_nxt = stat_w;
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         base_r <= `EBHA_BASE_RST;
         offs_r <= 16'h0000;
         wdata_r <= 8'h00;
         rdata_r <= 8'h00;
         write_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         tmo_r <= 1'b0;
         go_r <= 1'b0;
         dn_seen_r <= 1'b0;
         strap_r <= STRAP_VAL;
         dev_rst_r <= 1'b0;
      end
      else
      begin
         base_r <= base_nxt;
         offs_r <= offs_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
         write_r <= write_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         tmo_r <= tmo_nxt;
         go_r <= go_nxt;
         dn_seen_r <= dn_seen_nxt;
         strap_r <= strap_nxt;
         dev_rst_r <= dev_rst_nxt;
      end
   end

   // ---------------------------------------------
   // read data register; zero outside the answer cycle
   // ---------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rd_r <= 32'h0000_0000;
      end
      else
      begin
         rd_r <= rd_nxt;
      end
   end

   // ---------------------------------------------
   // done toggle from the link domain
   // ---------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         dn_s1_r <= 1'b0;
         dn_s2_r <= 1'b0;
      end
      else
      begin
         dn_s1_r <= link_done;
         dn_s2_r <= dn_s1_r;
      end
   end

   // ---------------------------------------------
   // reset carried into the link domain
   // ---------------------------------------------
   always_ff @(posedge host_port_clock)
   begin
      lrst_s1_r <= rst_n;
      lrst_s2_r <= lrst_s1_r;
   end

   // ---------------------------------------------
   // device data pins through two link-clock flops
   // ---------------------------------------------
   always_ff @(posedge host_port_clock)
   begin
      if (!lrst_s2_r)
      begin
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end
      else
      begin
         din_s1_r <= host_data_bus_in;
         din_s2_r <= din_s1_r;
      end
   end

   // ---------------------------------------------
   // request held stable while the link works on it
   // ---------------------------------------------
   assign req.write = write_r;
   assign req.addr = {base_r, offs_r}; // base byte in bits 23:16, which no pin carries
   assign req.data = wdata_r;

   ebha_link #(
      .TMO_CYC(TMO_CYC)
   ) u_link (
      .host_port_clock(host_port_clock),
      .link_rst_n(lrst_s2_r),
      .go_tgl(go_r),
      .req(req),
      .done_tgl(link_done),
      .rsp(rsp),
      .host_addr_upper(host_addr_upper),
      .host_addr_lsb(host_addr_lsb),
      .chip_select_n(chip_select_n),
      .upper_byte_enable_n(upper_byte_enable_n),
      .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n),
      .data_out(host_data_bus_out),
      .data_oe(host_data_bus_oe),
      .data_in(din_s2_r),
      .wait_n(wait_n)
   );

   // ---------------------------------------------
   // strap pins held steady around the device reset release
   // ---------------------------------------------
   assign straps = ebha_pkg::ebha_straps_t'(strap_r);
   assign bus_mode_straps = straps.bus_mode;
   assign byte_order_strap = straps.byte_order;
   assign panel_power_polarity_strap = straps.panel_power_polarity;
   assign bus_status_strap = straps.bus_status;
   assign direction_tie = 1'b1;
   assign device_reset_n = dev_rst_r;
   assign reg_rdata = rd_r;

endmodule : ebha_adapter

`default_nettype wire

// file: ebha_adapter_props.sv
// ebha_adapter_props.sv: port-level checker for the adapter
// assumes: bound to ebha_adapter; straps left at reset value by software
`timescale 1ns/100ps
`default_nettype none

module ebha_adapter_props #(
   parameter int TMO_CYC = 1000
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic host_port_clock,
   input wire logic host_addr_lsb,
   input wire logic chip_select_n,
   input wire logic upper_byte_enable_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [15:0] host_data_bus_out,
   input wire logic host_data_bus_oe,
   input wire logic wait_n,
   input wire logic direction_tie,
   input wire logic [2:0] bus_mode_straps,
   input wire logic bus_status_strap,
   input wire logic device_reset_n
);
   localparam int MAXW = TMO_CYC + 16;
   localparam int SAFE = TMO_CYC - 8;
   logic idle;
   logic [15:0] sc_r, sc_nxt;
   assign idle = write_strobe_n && read_strobe_n;
   // link cycles with a strobe low
   always_comb sc_nxt = (!rst_n || idle) ? 16'h0000 : sc_r + 16'h0001;
   always_ff @(posedge host_port_clock) sc_r <= sc_nxt;

   a_strobes_excl: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      write_strobe_n || read_strobe_n) else $error("both strobes low");
   a_strobe_sel: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      !idle |-> !chip_select_n) else $error("strobe without select");
   a_select_lead: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      $fell(idle) |-> $past(chip_select_n, 2) == 1'b0) else $error("select lead short");
   a_upper_enable: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      !chip_select_n |-> upper_byte_enable_n == !host_addr_lsb) else $error("upper enable bad");
   a_lane_mirror: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      host_data_bus_oe |-> host_data_bus_out[15:8] == host_data_bus_out[7:0])
      else $error("lanes differ");
   a_oe_write: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      host_data_bus_oe |-> !chip_select_n && read_strobe_n) else $error("drive outside write");
   a_wait_hold: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      (!wait_n && !idle && sc_r < SAFE) |=> !idle [*2]) else $error("strobe left during wait");
   a_wait_release: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      ($rose(wait_n) && !idle) |-> ##[1:4] idle) else $error("strobe stuck after wait");
   a_strobe_bound: assert property (@(posedge host_port_clock) disable iff (!rst_n)
      sc_r <= MAXW) else $error("strobe too long");
   a_dir_tied: assert property (@(posedge clock) disable iff (!rst_n)
      direction_tie) else $error("direction not high");
   a_mode_strap: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(device_reset_n) |-> (&bus_mode_straps) && bus_status_strap)
      else $error("mode straps not high");
   a_dev_reset: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> !device_reset_n ##[1:3] device_reset_n) else $error("device reset bad");
endmodule : ebha_adapter_props

bind ebha_adapter ebha_adapter_props #(.TMO_CYC(TMO_CYC)) u_ebha_adapter_props (
   .clock(clock), .rst_n(rst_n), .host_port_clock(host_port_clock),
   .host_addr_lsb(host_addr_lsb), .chip_select_n(chip_select_n),
   .upper_byte_enable_n(upper_byte_enable_n), .write_strobe_n(write_strobe_n),
   .read_strobe_n(read_strobe_n), .host_data_bus_out(host_data_bus_out),
   .host_data_bus_oe(host_data_bus_oe), .wait_n(wait_n), .direction_tie(direction_tie),
   .bus_mode_straps(bus_mode_straps), .bus_status_strap(bus_status_strap),
   .device_reset_n(device_reset_n));

`default_nettype wire

// file: ebha_dev_model.sv
// ebha_dev_model.sv: behavioural 16-bit display controller host port
// assumes: clocked by the link clock only; wait delay set by the bench
`timescale 1ns/100ps
`default_nettype none

module ebha_dev_model (
   input wire logic host_port_clock,
   input wire logic device_reset_n,
   input wire logic [15:1] host_addr_upper,
   input wire logic host_addr_lsb,
   input wire logic chip_select_n,
   input wire logic upper_byte_enable_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [15:0] dout,
   input wire logic doe,
   input wire ebha_pkg::ebha_straps_t straps,
   input wire logic [7:0] slow,
   output logic [15:0] bus,
   output logic wait_n
);
   logic [7:0] mem [0:65535]; // 64K block, buffer from 0000h, regs from ffe0h
   ebha_pkg::ebha_straps_t cap;
   logic [7:0] cnt;
   logic fin;
   logic [15:0] last = 16'h0000;
   logic [15:0] ev;
   assign ev = {host_addr_upper, 1'b0};
   // straps latched at reset release and held
   always @(posedge device_reset_n) cap <= straps;
   // wait low from select until arbitration ends, pull-up otherwise
   assign wait_n = chip_select_n | fin;
   // read word on both lanes; released bus toggles
   always_comb
   begin
      if (doe) bus = dout;
      else if (!chip_select_n && !read_strobe_n) bus = {mem[ev | 16'h0001], mem[ev]};
      else bus = ~last;
   end
   // arbitration delay and byte-lane writes
   always_ff @(posedge host_port_clock)
   begin
      last <= bus;
      if (chip_select_n || !device_reset_n)
      begin
         cnt <= 8'h00;
         fin <= 1'b0;
      end
      else if (!(write_strobe_n && read_strobe_n) && !fin)
      begin
         if (cnt >= slow)
         begin
            fin <= 1'b1;
            if (!write_strobe_n && !upper_byte_enable_n) mem[ev | 16'h0001] <= bus[15:8];
            else if (!write_strobe_n && !host_addr_lsb) mem[ev] <= bus[7:0];
         end
         else cnt <= cnt + 8'h01;
      end
   end
endmodule : ebha_dev_model

`default_nettype wire

// file: eight_bit_host_bus_adapter_bench.sv
// eight_bit_host_bus_adapter_bench.sv: register-level tests of the adapter
// assumes: device model on the link side; link clock 12 ns, system clock 8 ns
`timescale 1ns/100ps
`default_nettype none
`define EBHA_CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t got %h expected %h", $time, (a), (e)); end end

module eight_bit_host_bus_adapter_bench;
   logic clock, rst_n, host_port_clock, reg_write, reg_read, host_addr_lsb, chip_select_n;
   logic upper_byte_enable_n, write_strobe_n, read_strobe_n, host_data_bus_oe, wait_n;
   logic bus_status_strap, direction_tie, byte_order_strap, panel_power_polarity_strap;
   logic device_reset_n;
   logic [2:0] bus_mode_straps;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r;
   logic [15:1] host_addr_upper;
   logic [15:0] host_data_bus_out, host_data_bus_in;
   logic [7:0] slow, d;
   logic [15:0] offs [6] = '{16'h0000, 16'h9fff, 16'ha000, 16'hffdf, 16'hffe0, 16'hffff};
   int fails = 0;
   int n_compared = 0;

   ebha_adapter #(.TMO_CYC(50)) u_ebha_adapter (
      .clock(clock), .rst_n(rst_n), .host_port_clock(host_port_clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .host_addr_upper(host_addr_upper), .host_addr_lsb(host_addr_lsb),
      .chip_select_n(chip_select_n), .upper_byte_enable_n(upper_byte_enable_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
      .host_data_bus_in(host_data_bus_in), .wait_n(wait_n), .bus_status_strap(bus_status_strap),
      .direction_tie(direction_tie), .bus_mode_straps(bus_mode_straps),
      .byte_order_strap(byte_order_strap), .panel_power_polarity_strap(panel_power_polarity_strap),
      .device_reset_n(device_reset_n));

   ebha_dev_model u_ebha_dev_model (
      .host_port_clock(host_port_clock), .device_reset_n(device_reset_n),
      .host_addr_upper(host_addr_upper), .host_addr_lsb(host_addr_lsb),
      .chip_select_n(chip_select_n), .upper_byte_enable_n(upper_byte_enable_n),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .dout(host_data_bus_out), .doe(host_data_bus_oe),
      .straps({bus_status_strap, panel_power_polarity_strap, byte_order_strap, bus_mode_straps}),
      .slow(slow), .bus(host_data_bus_in), .wait_n(wait_n));

   // ------------------------------
   // clocks and bus tasks
   // ------------------------------
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial
   begin
      host_port_clock = 1'b0;
      #3;
      forever #6 host_port_clock = ~host_port_clock;
   end

   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // poll status until idle and done, bounded
   task automatic wait_done(output logic [31:0] st);
      int i;
      for (i = 0; i < 400; i++)
      begin
         rd(4'h4, st);
         if (st[1:0] === 2'b10) break;
      end
      if (i == 400)
      begin
         fails++;
         tally_and_finish();
      end
   endtask : wait_done

   task automatic xfer(input logic w, input logic [15:0] o, input logic [7:0] v,
                       output logic [31:0] st);
      wr(4'h1, {16'h0000, o});
      wr(4'h2, {24'h00_0000, v});
      wr(4'h0, w ? 32'h0000_0001 : 32'h0000_0002);
      wait_done(st);
   endtask : xfer

   // expected window flag from the block map
   function automatic logic win(input logic [15:0] o);
      return (o < 16'ha000) || (o >= 16'hffe0);
   endfunction : win

   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      rst_n = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      slow = 8'h00;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rd(4'h5, r);
      `EBHA_CHK(r, 32'h0000_002f)
      `EBHA_CHK(u_ebha_dev_model.cap, 6'h2f)
      rd(4'h6, r);
      `EBHA_CHK(r, 32'h0000_0001)
      rd(4'hf, r);
      `EBHA_CHK(r, 32'h0000_0000)
      // both lanes, buffer and register window edges
      foreach (offs[k])
      begin
         d = offs[k][7:0] ^ 8'h5a;
         xfer(1'b1, offs[k], d, r);
         `EBHA_CHK(r[3:0], {win(offs[k]), 3'b010})
         `EBHA_CHK(u_ebha_dev_model.mem[offs[k]], d)
         xfer(1'b0, offs[k], 8'h00, r);
         rd(4'h3, r);
         `EBHA_CHK(r[7:0], d)
      end
      // slow arbitration, then a wait longer than the timeout
      slow = 8'h14;
      xfer(1'b1, 16'h1235, 8'ha5, r);
      `EBHA_CHK(r[3:0], 4'b1010)
      `EBHA_CHK(u_ebha_dev_model.mem[16'h1235], 8'ha5)
      slow = 8'h50;
      xfer(1'b0, 16'h1235, 8'h00, r);
      `EBHA_CHK(r[2], 1'b1)
      slow = 8'h00;
      // address write while busy is ignored
      wr(4'h1, 32'h0000_0040);
      wr(4'h2, 32'h0000_003c);
      wr(4'h0, 32'h0000_0001);
      wr(4'h1, 32'h0000_0041);
      wait_done(r);
      `EBHA_CHK(r[2], 1'b0)
      `EBHA_CHK(u_ebha_dev_model.mem[16'h0040], 8'h3c)
      rd(4'h1, r);
      `EBHA_CHK(r[15:0], 16'h0040)
      tally_and_finish();
   end

   initial
   begin
      #400_000;
      fails++;
      tally_and_finish();
   end
endmodule : eight_bit_host_bus_adapter_bench

`default_nettype wire
